/* hw/pbca_bridge.v */
// PCI bridge controls and arbiter with AHB-Lite register access
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pbca_map.vh"

// Behaviour
// - Target posted write buffers used only when their enable bit is set.
// - Line read bit forces full line fetch; else single unless multiple/line command.
// - Write-invalidate bursts onto internal bus only with internal burst enable.
// - Back-off bit zero lets retried external masters reach system memory.
// - Raw clock bit is write-only; zero enables view, reads give no data.
// - Parity escalation bit drives SERR# when PERR# is driven or received.
// - Master write posting buffers memory writes; never I/O or locked writes.
// - Disconnect size field picks 128, 256, 512 or 1024 byte boundary.
// - Boundary select one disconnects at every 16-byte line instead.
// - Internal write wait bit inserts wait states on internal bus writes.
// - Second control register resets to 96h.
// - Arbiter control one resets to 80h; bit 6 reserved, written as one.
// - Grant policy one grants only while internal buffers are empty.
// - Per-request enable bits allow retry masking of REQ0#, REQ1#, REQ2#.
// - Retry mask interval field: none, 16, 32 or 64 PCI clocks.
module pbca_bridge (
    // Clock and reset
    input wire ref_clk,
    input wire rst,
    // AHB-Lite slave
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Target side
    input wire tgt_read_start,
    input wire [3:0] tgt_cmd,
    input wire tgt_write_start,
    input wire tgt_mwi,
    input wire tgt_data_valid,
    input wire [9:0] tgt_addr,
    input wire tgt_int_write,
    input wire retried_master,
    output reg tgt_line_fetch,
    output reg tgt_post_write,
    output reg int_burst,
    output reg tgt_disconnect,
    output reg int_write_wait,
    output reg retried_master_access,
    // Master side
    input wire mst_wr_valid,
    input wire mst_wr_io,
    input wire mst_wr_lock,
    input wire perr_driven,
    input wire perr_received,
    output reg mst_wr_post,
    output reg serr_out_n,
    output reg serr_oe,
    // Debug
    output reg raw_clk_view,
    // Arbiter
    input wire [2:0] req_n,
    input wire [2:0] retry_hit,
    input wire int_buffers_empty,
    output reg [2:0] gnt_n,
    // Interrupt
    output reg irq
);

    reg [3:0] ctl_one_reg;
    reg [7:0] ctl_two_reg;
    reg [7:0] arb_one_reg;
    reg raw_clk_reg;
    reg [`PBCA_IRQ_W-1:0] irq_stat_reg;
    reg [`PBCA_IRQ_W-1:0] irq_mask_reg;
    reg [`PBCA_IRQ_W-1:0] irq_set;
    reg [`PBCA_IRQ_W-1:0] irq_clr;

    // AHB state
    reg wr_pend_reg;
    reg rd_pend_reg;
    reg [7:0] idx_reg;
    reg [7:0] rd_val;
    reg [7:0] wbyte;
    wire addr_phase;
    wire [7:0] addr_idx;
    wire word_ok;

    assign addr_phase = hsel && htrans[1] && hready;
    assign addr_idx = haddr[9:2];
    assign word_ok = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);

    always @* begin
        wbyte = hwdata[7:0];
    end

    // Register read mux; bit 6 of control two never returns data
    always @* begin
        case (idx_reg)
            `PBCA_IDX_CTL_ONE: rd_val = {4'h0, ctl_one_reg};
            `PBCA_IDX_CTL_TWO: rd_val = {ctl_two_reg[7], 1'b0, ctl_two_reg[5:0]};
            `PBCA_IDX_RSVD_42: rd_val = 8'h00;
            `PBCA_IDX_ARB_ONE: rd_val = arb_one_reg;
            `PBCA_IDX_IRQ_STAT: rd_val = {5'h00, irq_stat_reg};
            `PBCA_IDX_IRQ_MASK: rd_val = {5'h00, irq_mask_reg};
            default: rd_val = 8'h00;
        endcase
    end

    // Reads take one wait state so a write just before is always seen
    always @(posedge ref_clk) begin
        if (rst) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            idx_reg <= 8'h00;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
            if (rd_pend_reg) begin
                hrdata <= {24'h000000, rd_val};
                hreadyout <= 1'b1;
                rd_pend_reg <= 1'b0;
            end else if (addr_phase) begin
                idx_reg <= word_ok ? addr_idx : 8'hff;
                wr_pend_reg <= hwrite;
                rd_pend_reg <= ~hwrite;
                hreadyout <= hwrite;
            end else begin
                wr_pend_reg <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge ref_clk) begin
        if (rst) begin
            ctl_one_reg <= `PBCA_RST_CTL_ONE;
            ctl_two_reg <= `PBCA_RST_CTL_TWO;
            arb_one_reg <= `PBCA_RST_ARB_ONE;
            raw_clk_reg <= 1'b0;
            irq_mask_reg <= 3'h0;
        end else if (wr_pend_reg) begin
            case (idx_reg)
                `PBCA_IDX_CTL_ONE: ctl_one_reg <= wbyte[3:0];
                `PBCA_IDX_CTL_TWO: begin
                    ctl_two_reg <= wbyte;
                    raw_clk_reg <= wbyte[`PBCA_B_RAW_CLK];
                end
                `PBCA_IDX_ARB_ONE: arb_one_reg <= wbyte;
                `PBCA_IDX_IRQ_MASK: irq_mask_reg <= wbyte[2:0];
                default: ;
            endcase
        end
    end

    // PCI clock enable from divider
    reg [2:0] div_reg;
    reg pci_tick;
    always @(posedge ref_clk) begin
        if (rst) begin
            div_reg <= 3'h0;
            pci_tick <= 1'b0;
        end else begin
            pci_tick <= (div_reg == `PBCA_PCI_DIV - 3'h1);
            div_reg <= (div_reg == `PBCA_PCI_DIV - 3'h1) ? 3'h0 : div_reg + 3'h1;
        end
    end

    // Target side controls
    reg [9:0] bnd_mask;
    reg at_boundary;
    always @* begin
        case (ctl_two_reg[`PBCA_B_BND_HI:`PBCA_B_BND_LO])
            2'h0: bnd_mask = 10'h07f;
            2'h1: bnd_mask = 10'h0ff;
            2'h2: bnd_mask = 10'h1ff;
            default: bnd_mask = 10'h3ff;
        endcase
        if (ctl_two_reg[`PBCA_B_BND_SEL]) begin
            bnd_mask = 10'h00f;
        end
        // Last word before the boundary ends the burst
        at_boundary = ((tgt_addr & bnd_mask) == (bnd_mask & 10'h3fc));
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            tgt_line_fetch <= 1'b0;
            tgt_post_write <= 1'b0;
            int_burst <= 1'b0;
            tgt_disconnect <= 1'b0;
            int_write_wait <= 1'b0;
            retried_master_access <= 1'b0;
            mst_wr_post <= 1'b0;
            serr_out_n <= 1'b1;
            serr_oe <= 1'b0;
            raw_clk_view <= 1'b0;
        end else begin
            if (tgt_read_start) begin
                tgt_line_fetch <= ctl_one_reg[`PBCA_B_LINE_READ] || (tgt_cmd == `PBCA_CMD_READ_MULT) ||
                    (tgt_cmd == `PBCA_CMD_READ_LINE);
            end
            if (tgt_write_start) begin
                tgt_post_write <= ctl_one_reg[`PBCA_B_TGT_WBUF];
            end
            int_burst <= tgt_mwi && ctl_one_reg[`PBCA_B_INT_BURST];
            tgt_disconnect <= tgt_data_valid && at_boundary;
            int_write_wait <= tgt_int_write && ctl_two_reg[`PBCA_B_INT_WAIT];
            retried_master_access <= retried_master && !ctl_one_reg[`PBCA_B_RETRIED_ACC];
            mst_wr_post <= mst_wr_valid && ctl_two_reg[`PBCA_B_MST_POST] && !mst_wr_io && !mst_wr_lock;
            serr_out_n <= !(ctl_two_reg[`PBCA_B_PARITY_ESC] && (perr_driven || perr_received));
            serr_oe <= ctl_two_reg[`PBCA_B_PARITY_ESC] && (perr_driven || perr_received);
            raw_clk_view <= !raw_clk_reg;
        end
    end

    // Retry mask counters, one per request line
    reg [6:0] mask_load;
    wire [2:0] masked;
    wire [2:0] mask_start;
    always @* begin
        case (arb_one_reg[`PBCA_B_MRM_HI:`PBCA_B_MRM_LO])
            2'h1: mask_load = `PBCA_MASK_16;
            2'h2: mask_load = `PBCA_MASK_32;
            2'h3: mask_load = `PBCA_MASK_64;
            default: mask_load = 7'h00;
        endcase
    end

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_mask
            reg [6:0] cnt_reg;
            assign mask_start[gi] = retry_hit[gi] && arb_one_reg[`PBCA_B_REQ0_MEN + gi] && (mask_load != 7'h00);
            assign masked[gi] = (cnt_reg != 7'h00);
            always @(posedge ref_clk) begin
                if (rst) begin
                    cnt_reg <= 7'h00;
                end else if (mask_start[gi]) begin
                    cnt_reg <= mask_load;
                end else if (pci_tick && masked[gi]) begin
                    cnt_reg <= cnt_reg - 7'h01;
                end
            end
        end
    endgenerate

    // Arbiter: fixed priority REQ0# highest; grant held until the request drops or a fresh retry mask starts
    localparam ARB_IDLE = 2'b01;
    localparam ARB_OWN = 2'b10;
    reg [1:0] arb_state_reg;
    reg [2:0] eligible;
    reg [2:0] pick;
    reg grant_ok;
    always @* begin
        eligible = ~req_n & ~masked;
        grant_ok = !arb_one_reg[`PBCA_B_GRANT_POL] || int_buffers_empty;
        pick = 3'h0;
        if (eligible[0]) begin
            pick = 3'h1;
        end else if (eligible[1]) begin
            pick = 3'h2;
        end else if (eligible[2]) begin
            pick = 3'h4;
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            arb_state_reg <= ARB_IDLE;
            gnt_n <= 3'h7;
        end else begin
            case (arb_state_reg)
                ARB_IDLE: begin
                    if (pick != 3'h0 && grant_ok) begin
                        gnt_n <= ~pick;
                        arb_state_reg <= ARB_OWN;
                    end
                end
                ARB_OWN: begin
                    // Release on request drop or a fresh retry mask
                    if ((~gnt_n & (req_n | mask_start)) != 3'h0) begin
                        gnt_n <= 3'h7;
                        arb_state_reg <= ARB_IDLE;
                    end
                end
                default: begin
                    gnt_n <= 3'h7;
                    arb_state_reg <= ARB_IDLE;
                end
            endcase
        end
    end

    // Interrupt status: set wins over write-one clear
    always @* begin
        irq_set = 3'h0;
        irq_set[`PBCA_IRQ_SERR] = ctl_two_reg[`PBCA_B_PARITY_ESC] && (perr_driven || perr_received);
        irq_set[`PBCA_IRQ_MASKED] = mask_start != 3'h0;
        irq_set[`PBCA_IRQ_DISC] = tgt_data_valid && at_boundary;
        irq_clr = (wr_pend_reg && idx_reg == `PBCA_IDX_IRQ_STAT) ? wbyte[2:0] : 3'h0;
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
            irq <= ((irq_stat_reg & ~irq_clr) & irq_mask_reg) != 3'h0 || (irq_set & irq_mask_reg) != 3'h0;
        end
    end

endmodule // pbca_bridge
`default_nettype wire

/* hw/pbca_map.vh */
// Register indices, field positions, reset values and timing counts
`ifndef PBCA_MAP_VH
`define PBCA_MAP_VH
// Register indices; byte address is four times the index
`define PBCA_IDX_CTL_ONE 8'h40
`define PBCA_IDX_CTL_TWO 8'h41
`define PBCA_IDX_RSVD_42 8'h42
`define PBCA_IDX_ARB_ONE 8'h43
`define PBCA_IDX_IRQ_STAT 8'h50
`define PBCA_IDX_IRQ_MASK 8'h51
// Reset values
`define PBCA_RST_CTL_ONE 4'h0
`define PBCA_RST_CTL_TWO 8'h96
`define PBCA_RST_ARB_ONE 8'h80
// Control one fields
`define PBCA_B_TGT_WBUF 3
`define PBCA_B_LINE_READ 2
`define PBCA_B_INT_BURST 1
`define PBCA_B_RETRIED_ACC 0
// Control two fields
`define PBCA_B_RAW_CLK 6
`define PBCA_B_PARITY_ESC 5
`define PBCA_B_MST_POST 4
`define PBCA_B_BND_HI 3
`define PBCA_B_BND_LO 2
`define PBCA_B_BND_SEL 1
`define PBCA_B_INT_WAIT 0
// Arbiter one fields
`define PBCA_B_GRANT_POL 7
`define PBCA_B_REQ0_MEN 3
`define PBCA_B_MRM_HI 2
`define PBCA_B_MRM_LO 1
// Interrupt status bits
`define PBCA_IRQ_SERR 0
`define PBCA_IRQ_MASKED 1
`define PBCA_IRQ_DISC 2
`define PBCA_IRQ_W 3
// PCI commands
`define PBCA_CMD_READ_MULT 4'hc
`define PBCA_CMD_READ_LINE 4'he
// Timing: PCI clock as an enable from the 125 MHz clock
`define PBCA_PCI_DIV 3'h4
`define PBCA_MASK_16 7'h10
`define PBCA_MASK_32 7'h20
`define PBCA_MASK_64 7'h40
`endif

/* hw/unused_placeholder_none.v */
// Intentionally empty design companion file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* verif/pbca_bridge_sva.sv */
// Port checker for the bridge controls and arbiter
`timescale 1ns/1ps
`default_nettype none
module pbca_bridge_chk (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Target side
    input wire logic tgt_read_start,
    input wire logic tgt_write_start,
    input wire logic tgt_mwi,
    input wire logic tgt_data_valid,
    input wire logic [9:0] tgt_addr,
    input wire logic tgt_int_write,
    input wire logic retried_master,
    input wire logic tgt_line_fetch,
    input wire logic tgt_post_write,
    input wire logic int_burst,
    input wire logic tgt_disconnect,
    input wire logic int_write_wait,
    input wire logic retried_master_access,
    // Master side
    input wire logic mst_wr_valid,
    input wire logic mst_wr_io,
    input wire logic mst_wr_lock,
    input wire logic perr_driven,
    input wire logic perr_received,
    input wire logic mst_wr_post,
    input wire logic serr_out_n,
    // Arbiter
    input wire logic [2:0] req_n,
    input wire logic [2:0] gnt_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    property p_twb; $changed(tgt_post_write) |-> $past(tgt_write_start); endproperty
    a_twb: assert property (p_twb) else $error("post flag moved without write start");
    property p_line; $changed(tgt_line_fetch) |-> $past(tgt_read_start); endproperty
    a_line: assert property (p_line) else $error("line fetch moved without read start");
    property p_burst; int_burst |-> $past(tgt_mwi); endproperty
    a_burst: assert property (p_burst) else $error("burst without write invalidate");
    property p_acc; retried_master_access |-> $past(retried_master); endproperty
    a_acc: assert property (p_acc) else $error("access without retried master");
    property p_serr; !serr_out_n |-> $past(perr_driven || perr_received); endproperty
    a_serr: assert property (p_serr) else $error("system error without parity error");
    property p_post; mst_wr_post |-> $past(mst_wr_valid && !mst_wr_io && !mst_wr_lock); endproperty
    a_post: assert property (p_post) else $error("posted io, locked or absent write");
    property p_disc; tgt_disconnect |-> $past(tgt_data_valid) && $past(tgt_addr[3:2]) == 2'h3; endproperty
    a_disc: assert property (p_disc) else $error("disconnect off a boundary word");
    property p_wait; int_write_wait |-> $past(tgt_int_write); endproperty
    a_wait: assert property (p_wait) else $error("wait state without internal write");
    // Grant only to a requester, one at a time
    property p_gnt; gnt_n != 3'h7 |-> $onehot(~gnt_n) && (~gnt_n & $past(req_n)) == 3'h0; endproperty
    a_gnt: assert property (p_gnt) else $error("grant to a master not requesting");
    c_disc: cover property (tgt_disconnect);
    c_gnt: cover property ($fell(gnt_n[2]));
    c_serr: cover property (!serr_out_n);
endmodule // pbca_bridge_chk
bind pbca_bridge pbca_bridge_chk pbca_bridge_chk_inst (.ref_clk, .rst, .tgt_read_start, .tgt_write_start,
    .tgt_mwi, .tgt_data_valid, .tgt_addr, .tgt_int_write, .retried_master, .tgt_line_fetch, .tgt_post_write,
    .int_burst, .tgt_disconnect, .int_write_wait, .retried_master_access, .mst_wr_valid, .mst_wr_io,
    .mst_wr_lock, .perr_driven, .perr_received, .mst_wr_post, .serr_out_n, .req_n, .gnt_n);
`default_nettype wire

/* verif/pbca_pci_model.sv */
// Behavioural external PCI masters on the request lines
`timescale 1ns/1ps
`default_nettype none
module pbca_pci_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Masters wanting the bus and tenure length
    input wire logic [2:0] want,
    input wire logic [7:0] hold,
    // Arbitration
    input wire logic [2:0] gnt_n,
    output logic [2:0] req_n
);
    logic [7:0] cnt_reg;
    // Owner drops its request for one cycle after a tenure so others get a turn
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            req_n <= 3'h7;
            cnt_reg <= 8'h00;
        end else if (gnt_n != 3'h7 && cnt_reg >= hold) begin
            req_n <= ~want | ~gnt_n;
            cnt_reg <= 8'h00;
        end else begin
            req_n <= ~want;
            cnt_reg <= (gnt_n != 3'h7) ? cnt_reg + 8'h01 : 8'h00;
        end
    end
endmodule // pbca_pci_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the bridge controls and arbiter
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, tgt_line_fetch, tgt_post_write;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv;
    logic [1:0] htrans = 2'h0;
    logic int_burst, tgt_disconnect, int_write_wait, retried_master_access, mst_wr_post, serr_out_n, serr_oe;
    logic raw_clk_view, irq, tgt_read_start = 1'b0, tgt_write_start = 1'b0, tgt_mwi = 1'b0, tgt_data_valid = 1'b0;
    logic tgt_int_write = 1'b0, retried_master = 1'b0, mst_wr_valid = 1'b0, mst_wr_io = 1'b0, mst_wr_lock = 1'b0;
    logic perr_driven = 1'b0, perr_received = 1'b0, int_buffers_empty = 1'b0;
    logic [3:0] tgt_cmd = 4'h0;
    logic [9:0] tgt_addr = 10'h0;
    logic [2:0] req_n, gnt_n, want = 3'h0, retry_hit = 3'h0;
    logic [7:0] hold = 8'hff;
    int n_errors = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    pbca_bridge pbca_bridge_inst (.ref_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tgt_read_start, .tgt_cmd, .tgt_write_start, .tgt_mwi,
        .tgt_data_valid, .tgt_addr, .tgt_int_write, .retried_master, .tgt_line_fetch, .tgt_post_write, .int_burst,
        .tgt_disconnect, .int_write_wait, .retried_master_access, .mst_wr_valid, .mst_wr_io, .mst_wr_lock,
        .perr_driven, .perr_received, .mst_wr_post, .serr_out_n, .serr_oe, .raw_clk_view, .req_n, .retry_hit,
        .int_buffers_empty, .gnt_n, .irq);
    pbca_pci_model pbca_pci_model_inst (.ref_clk, .rst, .want, .hold, .gnt_n, .req_n);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Address phase held until ready, then data phase held until ready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {hsel, htrans, haddr, hwrite} <= {3'h6, a, w};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        {hsel, htrans} <= 3'h0;
        if (w) hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task automatic t_reset;
        rdchk(32'h104, 32'h96);
        rdchk(32'h10c, 32'h80);
        wr(32'h108, 32'hff);
        rdchk(32'h108, 32'h0);
        rdchk(32'h200, 32'h0);
        chk(raw_clk_view, 1'b1);
        $display("t_reset done");
    endtask
    task automatic t_ctl1(input logic [3:0] v);
        wr(32'h100, {28'h0, v});
        {tgt_read_start, tgt_write_start, tgt_mwi, retried_master, tgt_cmd} <= {4'hf, 4'h6};
        @(posedge ref_clk);
        {tgt_read_start, tgt_write_start} <= 2'h0;
        tick(2);
        chk(tgt_post_write, v[3]);
        chk(tgt_line_fetch, v[2]);
        chk(int_burst, v[1]);
        chk(retried_master_access, !v[0]);
        {tgt_read_start, tgt_cmd} <= {1'b1, v[0] ? 4'hc : 4'he};
        @(posedge ref_clk);
        {tgt_read_start, tgt_mwi, retried_master} <= 3'h0;
        tick(2);
        chk(tgt_line_fetch, 1'b1);
        $display("t_ctl1 %h done", v);
    endtask
    task automatic t_ctl2(input logic [7:0] v);
        wr(32'h104, {24'h0, v});
        {perr_driven, mst_wr_valid, tgt_int_write} <= 3'h7;
        tick(3);
        chk({serr_out_n, serr_oe}, {~v[5], v[5]});
        chk(mst_wr_post, v[4]);
        chk(int_write_wait, v[0]);
        chk(raw_clk_view, !v[6]);
        {mst_wr_io, perr_driven, perr_received} <= 3'h5;
        tick(3);
        chk({mst_wr_post, serr_oe}, {1'b0, v[5]});
        {mst_wr_io, mst_wr_lock} <= 2'h1;
        tick(3);
        chk(mst_wr_post, 1'b0);
        {mst_wr_valid, mst_wr_lock, tgt_int_write, perr_received} <= 4'h0;
        rdchk(32'h104, {24'h0, v & 8'h3f});
        $display("t_ctl2 %h done", v);
    endtask
    task automatic t_disc(input logic [7:0] v, input logic [10:0] b);
        wr(32'h104, {24'h0, v});
        for (int k = 4; k <= 8; k += 4) begin
            {tgt_data_valid, tgt_addr} <= {1'b1, 10'(b - k)};
            @(posedge ref_clk);
            tgt_data_valid <= 1'b0;
            tick(1);
            chk(tgt_disconnect, k == 4);
        end
        $display("t_disc %h done", v);
    endtask
    task automatic t_policy;
        want <= 3'h1;
        tick(20);
        chk(gnt_n, 3'h7);
        int_buffers_empty <= 1'b1;
        tick(4);
        chk(gnt_n, 3'h6);
        {want, int_buffers_empty} <= 4'h0;
        wr(32'h10c, 32'h40);
        want <= 3'h1;
        tick(4);
        chk(gnt_n, 3'h6);
        {want, int_buffers_empty} <= 4'h1;
        tick(4);
        $display("t_policy done");
    endtask
    // Time from a retry of master i until it is granted again; unmasked owner keeps its grant
    task automatic t_arb(input int i, input logic [7:0] a, input int lo, input int hi);
        int c = 0;
        wr(32'h10c, {24'h0, a});
        want <= 3'(1 << i);
        do @(posedge ref_clk); while (gnt_n[i] !== 1'b0 && ++c < 50);
        retry_hit <= 3'(1 << i);
        @(posedge ref_clk);
        retry_hit <= 3'h0;
        c = 0;
        do @(posedge ref_clk); while (gnt_n[i] !== 1'b0 && ++c < 400);
        chk(c >= lo && c <= hi, 1'b1);
        want <= 3'h0;
        tick(4);
        $display("t_arb %0d %h done", i, a);
    endtask
    task automatic t_irq;
        wr(32'h140, 32'h7);
        wr(32'h104, 32'h20);
        perr_received <= 1'b1;
        @(posedge ref_clk);
        perr_received <= 1'b0;
        tick(3);
        chk(irq, 1'b0);
        rdchk(32'h140, 32'h1);
        wr(32'h144, 32'h1);
        tick(2);
        chk(irq, 1'b1);
        wr(32'h140, 32'h1);
        tick(2);
        chk(irq, 1'b0);
        rdchk(32'h140, 32'h0);
        $display("t_irq done");
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        tick(3);
        rst <= 1'b0;
        t_reset;
        t_ctl1(4'hf);
        t_ctl1(4'h0);
        t_ctl2(8'h71);
        t_ctl2(8'h00);
        t_disc(8'h00, 11'h80);
        t_disc(8'h04, 11'h100);
        t_disc(8'h08, 11'h200);
        t_disc(8'h0c, 11'h400);
        t_disc(8'h0e, 11'h10);
        t_policy;
        t_arb(0, 8'h4a, 60, 72);
        t_arb(1, 8'h54, 124, 136);
        t_arb(2, 8'h66, 252, 264);
        t_arb(0, 8'h76, 0, 0);
        t_arb(0, 8'h48, 0, 0);
        t_irq;
        results;
    end
    // Run needs under a thousand cycles; this is over ten times that
    initial begin
        #100000;
        n_errors++;
        results;
    end
endmodule // tb
`default_nettype wire
